/* File: rtl/bsrs_register_set.v */
// instruction register, decoder and test data registers of a scan port
`timescale 1ns/1ps
`include "bsrs_consts.vh"

module bsrs_register_set (
  // clock and reset
  input  wire                     clk_i,
  input  wire                     rst_i,
  // test bus pins
  input  wire                     tck_i,
  input  wire                     tdi_i,
  output reg                      tdo_o,
  output reg                      tdo_oe_o,
  // tap state levels
  input  wire                     tap_reset_i,
  input  wire                     capture_ir_i,
  input  wire                     shift_ir_i,
  input  wire                     update_ir_i,
  input  wire                     capture_dr_i,
  input  wire                     shift_dr_i,
  input  wire                     update_dr_i,
  input  wire                     run_idle_i,
  // chain capture and alteration
  input  wire [`BSRS_CHAIN_W-1:0] pin_cell_obs_i,
  input  wire                     chain_alter_i,
  input  wire [`BSRS_CHAIN_W-1:0] chain_alter_data_i,
  // decoded instruction and operation select
  output reg  [`BSRS_IR_W-1:0]    instruction_o,
  output reg  [1:0]               selected_reg_o,
  output reg  [1:0]               mode_o,
  output reg  [1:0]               capture_src_o,
  output reg                      run_selected_test_o,
  output reg                      toggle_outputs_only_o,
  output reg  [`BSRS_OPS_W-1:0]   operation_select_o,
  // chain shadow and shift stages
  output reg  [`BSRS_CHAIN_W-1:0] pin_cell_chain_o,
  output reg  [`BSRS_CHAIN_W-1:0] pin_cell_shift_o
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers: every pin passes two flops before use
  wire [`BSRS_SYNC_W-1:0]  lvl_s;
  wire [`BSRS_CHAIN_W-1:0] obs_s;
  wire [`BSRS_CHAIN_W-1:0] altd_s;
  reg                      tck_d_r;

  // tck, tdi and tap levels share one synchroniser so they keep one depth
  bsrs_sync2 #(
    .W (`BSRS_SYNC_W)
  ) u_sync_lvl (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({tck_i,
             tdi_i,
             tap_reset_i,
             capture_ir_i,
             shift_ir_i,
             update_ir_i,
             capture_dr_i,
             shift_dr_i,
             update_dr_i,
             run_idle_i,
             chain_alter_i}),
    .q_o   (lvl_s)
  );

  // wide words are only used on tck edges, long after they have settled
  bsrs_sync2 #(
    .W (`BSRS_CHAIN_W)
  ) u_sync_obs (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (pin_cell_obs_i),
    .q_o   (obs_s)
  );

  bsrs_sync2 #(
    .W (`BSRS_CHAIN_W)
  ) u_sync_alt (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (chain_alter_data_i),
    .q_o   (altd_s)
  );

  // reset level equals the idle low tck, so no false edge follows reset
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tck_d_r <= 1'b0;
    end else begin
      tck_d_r <= lvl_s[`BSRS_SY_TCK];
    end
  end

  // tap levels travel the same depth as tck, so they stay aligned to its edges
  wire tck_rise = lvl_s[`BSRS_SY_TCK] & ~tck_d_r;
  wire tck_fall = ~lvl_s[`BSRS_SY_TCK] & tck_d_r;
  wire tdi_s    = lvl_s[`BSRS_SY_TDI];
  wire tlr_s    = lvl_s[`BSRS_SY_TLR];
  wire cap_ir_s = lvl_s[`BSRS_SY_CAP_IR];
  wire sh_ir_s  = lvl_s[`BSRS_SY_SH_IR];
  wire upd_ir_s = lvl_s[`BSRS_SY_UPD_IR];
  wire cap_dr_s = lvl_s[`BSRS_SY_CAP_DR];
  wire sh_dr_s  = lvl_s[`BSRS_SY_SH_DR];
  wire upd_dr_s = lvl_s[`BSRS_SY_UPD_DR];
  wire idle_s   = lvl_s[`BSRS_SY_IDLE];
  wire alter_s  = lvl_s[`BSRS_SY_ALTER];

  ////////////////////////////////////////////////////////////////////////////
  // opcode decoder
  reg [`BSRS_IR_W-1:0] ir_shift_r;
  reg [`BSRS_IR_W-1:0] ir_cur_r;
  reg [1:0]            sel_nxt;
  reg [1:0]            mode_nxt;
  reg [1:0]            cap_nxt;

  // parity is never examined; every pattern decodes
  always @* begin
    sel_nxt  = `BSRS_SEL_SHORT;
    mode_nxt = `BSRS_MODE_NORMAL;
    cap_nxt  = `BSRS_CAP_PINS;
    case (ir_cur_r[`BSRS_OPC_W-1:0])
      `BSRS_OPC_SCAN_A, `BSRS_OPC_SCAN_B: begin
        sel_nxt  = `BSRS_SEL_CHAIN;
        mode_nxt = `BSRS_MODE_TEST;
      end
      `BSRS_OPC_SAMPLE: begin
        sel_nxt  = `BSRS_SEL_CHAIN;
      end
      `BSRS_OPC_FLOAT: begin
        mode_nxt = `BSRS_MODE_FLOAT;
      end
      `BSRS_OPC_HOLD, `BSRS_OPC_RUN_SELECTED_TEST, `BSRS_OPC_TOGGLE: begin
        mode_nxt = `BSRS_MODE_TEST;
      end
      `BSRS_OPC_READN: begin
        sel_nxt  = `BSRS_SEL_CHAIN;
        cap_nxt  = `BSRS_CAP_HOLD;
      end
      `BSRS_OPC_READT: begin
        sel_nxt  = `BSRS_SEL_CHAIN;
        mode_nxt = `BSRS_MODE_TEST;
        cap_nxt  = `BSRS_CAP_HOLD;
      end
      `BSRS_OPC_CELLCHK: begin
        sel_nxt  = `BSRS_SEL_CHAIN;
        cap_nxt  = `BSRS_CAP_INVERT;
      end
      `BSRS_OPC_OPSELN: begin
        sel_nxt  = `BSRS_SEL_OPS;
      end
      `BSRS_OPC_OPSELT: begin
        sel_nxt  = `BSRS_SEL_OPS;
        mode_nxt = `BSRS_MODE_TEST;
      end
      default: begin
        sel_nxt  = `BSRS_SEL_SHORT;
      end
    endcase
  end

  wire is_run_selected_test   = (ir_cur_r[`BSRS_OPC_W-1:0] == `BSRS_OPC_RUN_SELECTED_TEST);
  wire is_toggle = (ir_cur_r[`BSRS_OPC_W-1:0] == `BSRS_OPC_TOGGLE);

  ////////////////////////////////////////////////////////////////////////////
  // instruction register: shift stages
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ir_shift_r <= `BSRS_IR_RESET;
    end else if (tlr_s) begin
      ir_shift_r <= `BSRS_IR_RESET;
    end else if (tck_rise && cap_ir_s) begin
      ir_shift_r <= `BSRS_IR_CAPTURE;
    end else if (tck_rise && sh_ir_s) begin
      ir_shift_r <= {tdi_s, ir_shift_r[`BSRS_IR_W-1:1]};
    end
  end

  // shadow: the decoder never sees a half-shifted instruction
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ir_cur_r <= `BSRS_IR_RESET;
    end else if (tlr_s) begin
      ir_cur_r <= `BSRS_IR_RESET;
    end else if (tck_fall && upd_ir_s) begin
      ir_cur_r <= ir_shift_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data registers
  reg [`BSRS_CHAIN_W-1:0] chain_sh_r;
  reg [`BSRS_CHAIN_W-1:0] chain_shadow_r;
  reg [`BSRS_OPS_W-1:0]   ops_sh_r;
  reg [`BSRS_OPS_W-1:0]   ops_shadow_r;
  reg                     short_r;
  wire sel_chain = (sel_nxt == `BSRS_SEL_CHAIN);
  wire sel_ops   = (sel_nxt == `BSRS_SEL_OPS);
  wire sel_short = (sel_nxt == `BSRS_SEL_SHORT);

  // chain has no reset from the tap; power-up clears it only for a defined start
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      chain_sh_r <= {`BSRS_CHAIN_W{1'b0}};
    end else if (tck_rise && cap_dr_s && sel_chain) begin
      case (cap_nxt)
        `BSRS_CAP_HOLD:   chain_sh_r <= chain_sh_r;
        `BSRS_CAP_INVERT: chain_sh_r <= ~chain_shadow_r;
        default:          chain_sh_r <= obs_s;
      endcase
    end else if (tck_rise && sh_dr_s && sel_chain) begin
      chain_sh_r <= {tdi_s, chain_sh_r[`BSRS_CHAIN_W-1:1]};
    end else if (tck_rise && idle_s && alter_s) begin
      chain_sh_r <= altd_s;
    end
  end

  // shadow moves on falling tck only, half a cycle after the stages settle
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      chain_shadow_r <= {`BSRS_CHAIN_W{1'b0}};
    end else if (tck_fall && upd_dr_s && sel_chain) begin
      chain_shadow_r <= chain_sh_r;
    end else if (tck_fall && idle_s && alter_s) begin
      chain_shadow_r <= chain_sh_r;
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ops_sh_r <= `BSRS_OPS_RESET;
    end else if (tlr_s) begin
      ops_sh_r <= `BSRS_OPS_RESET;
    end else if (tck_rise && cap_dr_s && sel_ops) begin
      ops_sh_r <= ops_sh_r;
    end else if (tck_rise && sh_dr_s && sel_ops) begin
      ops_sh_r <= {tdi_s, ops_sh_r[`BSRS_OPS_W-1:1]};
    end
  end

  // active operation stays put while a new code is shifted past it
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ops_shadow_r <= `BSRS_OPS_RESET;
    end else if (tlr_s) begin
      ops_shadow_r <= `BSRS_OPS_RESET;
    end else if (tck_fall && upd_dr_s && sel_ops) begin
      ops_shadow_r <= ops_sh_r;
    end
  end

  // single stage, no shadow
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      short_r <= 1'b0;
    end else if (tck_rise && cap_dr_s && sel_short) begin
      short_r <= 1'b0;
    end else if (tck_rise && sh_dr_s && sel_short) begin
      short_r <= tdi_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tdo and registered outputs
  reg tdo_nxt;

  always @* begin
    tdo_nxt = ir_shift_r[0];
    if (sh_dr_s) begin
      case (sel_nxt)
        `BSRS_SEL_CHAIN: tdo_nxt = chain_sh_r[0];
        `BSRS_SEL_OPS:   tdo_nxt = ops_sh_r[0];
        default:         tdo_nxt = short_r;
      endcase
    end
  end

  // tdo moves only on falling tck so the master samples a settled bit
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else if (tck_fall) begin
      tdo_o    <= tdo_nxt;
      tdo_oe_o <= sh_ir_s | sh_dr_s;
    end
  end

  // decode outputs share the shadow's timing, one clk after it
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      instruction_o  <= `BSRS_IR_RESET;
      selected_reg_o <= `BSRS_SEL_SHORT;
      mode_o         <= `BSRS_MODE_NORMAL;
      capture_src_o  <= `BSRS_CAP_PINS;
    end else begin
      instruction_o  <= ir_cur_r;
      selected_reg_o <= sel_nxt;
      mode_o         <= mode_nxt;
      capture_src_o  <= cap_nxt;
    end
  end

  // the algorithms outside only see these levels, never the tap state
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_selected_test_o   <= 1'b0;
      toggle_outputs_only_o <= 1'b0;
    end else begin
      run_selected_test_o   <= is_run_selected_test & idle_s & ~tlr_s;
      toggle_outputs_only_o <= is_toggle & idle_s & ~tlr_s;
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      operation_select_o <= `BSRS_OPS_RESET;
      pin_cell_chain_o   <= {`BSRS_CHAIN_W{1'b0}};
      pin_cell_shift_o   <= {`BSRS_CHAIN_W{1'b0}};
    end else begin
      operation_select_o <= ops_shadow_r;
      pin_cell_chain_o   <= chain_shadow_r;
      pin_cell_shift_o   <= chain_sh_r;
    end
  end

endmodule

////////////////////////////////////////////////////////////////////////////
// two-flop synchroniser; only the second stage is read outside
module bsrs_sync2 #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);

  reg [W-1:0] meta_r;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= {W{1'b0}};
      q_o    <= {W{1'b0}};
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end

endmodule

/* File: rtl/bsrs_consts.vh */
// constants for the boundary scan register set
`ifndef BSRS_CONSTS_VH
`define BSRS_CONSTS_VH

// register widths
`define BSRS_IR_W        8
`define BSRS_CHAIN_W     18
`define BSRS_OPS_W       2
`define BSRS_OPC_W       7

// capture and reset values
`define BSRS_IR_CAPTURE  8'h81
`define BSRS_IR_RESET    8'hff
`define BSRS_OPS_RESET   2'h2

// chain cell positions
`define BSRS_CELL_CLK    17
`define BSRS_CELL_OE     16
`define BSRS_CELL_DIN_HI 15
`define BSRS_CELL_DIN_LO 8
`define BSRS_CELL_Q_HI   7
`define BSRS_CELL_Q_LO   0

// opcodes with the top bit dropped
`define BSRS_OPC_SCAN_A  7'h00
`define BSRS_OPC_SAMPLE  7'h02
`define BSRS_OPC_SCAN_B  7'h03
`define BSRS_OPC_FLOAT   7'h06
`define BSRS_OPC_HOLD    7'h07
`define BSRS_OPC_RUN_SELECTED_TEST    7'h09
`define BSRS_OPC_READN   7'h0a
`define BSRS_OPC_READT   7'h0b
`define BSRS_OPC_CELLCHK 7'h0c
`define BSRS_OPC_TOGGLE  7'h0d
`define BSRS_OPC_OPSELN  7'h0e
`define BSRS_OPC_OPSELT  7'h0f

// selected data register
`define BSRS_SEL_SHORT   2'h0
`define BSRS_SEL_CHAIN   2'h1
`define BSRS_SEL_OPS     2'h2

// operating mode
`define BSRS_MODE_NORMAL 2'h0
`define BSRS_MODE_TEST   2'h1
`define BSRS_MODE_FLOAT  2'h2

// chain capture source
`define BSRS_CAP_PINS    2'h0
`define BSRS_CAP_HOLD    2'h1
`define BSRS_CAP_INVERT  2'h2

// synchroniser layout
`define BSRS_SYNC_W      11
`define BSRS_SY_TCK      10
`define BSRS_SY_TDI      9
`define BSRS_SY_TLR      8
`define BSRS_SY_CAP_IR   7
`define BSRS_SY_SH_IR    6
`define BSRS_SY_UPD_IR   5
`define BSRS_SY_CAP_DR   4
`define BSRS_SY_SH_DR    3
`define BSRS_SY_UPD_DR   2
`define BSRS_SY_IDLE     1
`define BSRS_SY_ALTER    0

`endif

/* File: test/bsrs_register_set_properties.sv */
// concurrent checks on the ports of the scan register set
`timescale 1ns/1ps
`include "bsrs_consts.vh"
module bsrs_register_set_props (
  input wire        clk_i, rst_i, tdo_o, tdo_oe_o, tap_reset_i,
  input wire        shift_ir_i, shift_dr_i, update_ir_i, update_dr_i, run_idle_i,
  input wire        run_selected_test_o, toggle_outputs_only_o,
  input wire [7:0]  instruction_o,
  input wire [1:0]  selected_reg_o, mode_o, operation_select_o,
  input wire [17:0] pin_cell_chain_o
);
  // top bit dropped on purpose
  function [3:0] dec(input [7:0] o);
    case (o[6:0])
      7'h00, 7'h03, 7'h0b: dec = {`BSRS_SEL_CHAIN, `BSRS_MODE_TEST};
      7'h02, 7'h0a, 7'h0c: dec = {`BSRS_SEL_CHAIN, `BSRS_MODE_NORMAL};
      7'h06: dec = {`BSRS_SEL_SHORT, `BSRS_MODE_FLOAT};
      7'h07, 7'h09, 7'h0d: dec = {`BSRS_SEL_SHORT, `BSRS_MODE_TEST};
      7'h0e: dec = {`BSRS_SEL_OPS, `BSRS_MODE_NORMAL};
      7'h0f: dec = {`BSRS_SEL_OPS, `BSRS_MODE_TEST};
      default: dec = {`BSRS_SEL_SHORT, `BSRS_MODE_NORMAL};
    endcase
  endfunction
  wire shifting = shift_ir_i | shift_dr_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  // two stable samples so either decode lag passes
  chk_decode_map: assert property ($stable(instruction_o) [*2] |->
    {selected_reg_o, mode_o} == dec(instruction_o)) else $error("decode mismatch");
  chk_tlr_ir: assert property (tap_reset_i [*6] |=> instruction_o == 8'hff)
    else $error("instruction not all ones in tap reset");
  chk_tlr_ops: assert property (tap_reset_i [*6] |=> operation_select_o == 2'h2)
    else $error("operation select not reset");
  chk_tlr_chain: assert property (tap_reset_i [*6] |=> $stable(pin_cell_chain_o))
    else $error("chain changed in tap reset");
  chk_ir_when: assert property ($changed(instruction_o) |-> update_ir_i || tap_reset_i)
    else $error("instruction changed outside update");
  chk_ops_when: assert property ($changed(operation_select_o) |-> update_dr_i || tap_reset_i)
    else $error("operation select changed outside update");
  chk_chain_when: assert property ($changed(pin_cell_chain_o) |-> update_dr_i || run_idle_i)
    else $error("chain shadow changed outside update");
  chk_oe_rise: assert property ($rose(tdo_oe_o) |-> shifting ##1 tdo_oe_o [*7])
    else $error("tdo enable outside shift");
  chk_oe_fall: assert property ($fell(tdo_oe_o) |-> !shifting)
    else $error("tdo enable held after shift");
  chk_ir_first: assert property ($rose(tdo_oe_o) && shift_ir_i |-> tdo_o)
    else $error("first instruction bit out not one");
  chk_run_only: assert property (run_selected_test_o |-> instruction_o[6:0] == 7'h09)
    else $error("run test without its instruction");
  chk_run_idle: assert property ($rose(run_selected_test_o) |-> run_idle_i)
    else $error("run test outside idle");
  chk_toggle_only: assert property (toggle_outputs_only_o |-> instruction_o[6:0] == 7'h0d)
    else $error("toggle without its instruction");
  cov_run: cover property ($rose(run_selected_test_o));
  cov_tog: cover property ($rose(toggle_outputs_only_o));
  cov_ops: cover property ($changed(operation_select_o) && update_dr_i);
endmodule
bind bsrs_register_set bsrs_register_set_props u_props (
  .clk_i(clk_i), .rst_i(rst_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
  .tap_reset_i(tap_reset_i), .shift_ir_i(shift_ir_i), .shift_dr_i(shift_dr_i),
  .update_ir_i(update_ir_i), .update_dr_i(update_dr_i), .run_idle_i(run_idle_i),
  .run_selected_test_o(run_selected_test_o), .toggle_outputs_only_o(toggle_outputs_only_o),
  .instruction_o(instruction_o), .selected_reg_o(selected_reg_o), .mode_o(mode_o),
  .operation_select_o(operation_select_o), .pin_cell_chain_o(pin_cell_chain_o)
);

/* File: test/bsrs_tap_master.sv */
// behavioural test bus master driving the scan port
`timescale 1ns/1ps
module bsrs_tap_master (
  input  wire       clk_i,
  input  wire       tdo_i,
  output reg        tck_o,
  output reg        tdi_o,
  output reg  [7:0] st_o
);
  // st_o: tlr, cap ir, sh ir, upd ir, cap dr, sh dr, upd dr, idle
  initial begin
    tck_o = 1'b0;
    tdi_o = 1'b0;
    st_o  = 8'h80;
  end
  // state moves late in the high phase so the ending rise sees the old one
  task step(input [7:0] st, input d, output q);
    begin
      st_o  = st;
      tdi_o = d;
      @(posedge clk_i) #1 tck_o = 1'b0;
      repeat (4) @(posedge clk_i);
      #1 tck_o = 1'b1;
      repeat (2) @(posedge clk_i);
      #1 q = tdo_i;
      @(posedge clk_i) #1;
    end
  endtask
  task scan(input ir, input [17:0] din, input integer n, output [17:0] dout);
    integer i;
    reg     q;
    begin
      dout = 18'h0;
      step(ir ? 8'h40 : 8'h08, 1'b0, q);
      for (i = 0; i < n; i = i + 1) begin
        step(ir ? 8'h20 : 8'h04, din[i], q);
        dout[i] = q;
      end
      step(8'h00, 1'b0, q);
      step(ir ? 8'h10 : 8'h02, 1'b0, q);
      step(8'h01, 1'b0, q);
    end
  endtask
endmodule

/* File: test/bsrs_register_set_test.sv */
// self-checking bench for the scan register set
`timescale 1ns/1ps
`include "bsrs_consts.vh"
`define CHK(a, b) begin checked = checked + 1; if ((a) !== (b)) begin \
  num_errors = num_errors + 1; $display("BAD %0t got %h want %h", $time, a, b); end end
module bsrs_register_set_test;
  reg         clk_i, rst_i, alt, q;
  reg  [17:0] obs, altd, d;
  reg  [7:0]  v;
  integer     i, num_errors, checked;
  wire        tck, tdi, tdo, oe, run, tog;
  wire [7:0]  st, ins;
  wire [1:0]  sel, mode, csrc, ops;
  wire [17:0] chn, shf;
  bsrs_register_set dut (
    .clk_i(clk_i), .rst_i(rst_i), .tck_i(tck), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(oe),
    .tap_reset_i(st[7]), .capture_ir_i(st[6]), .shift_ir_i(st[5]), .update_ir_i(st[4]),
    .capture_dr_i(st[3]), .shift_dr_i(st[2]), .update_dr_i(st[1]), .run_idle_i(st[0]),
    .pin_cell_obs_i(obs), .chain_alter_i(alt), .chain_alter_data_i(altd),
    .instruction_o(ins), .selected_reg_o(sel), .mode_o(mode), .capture_src_o(csrc),
    .run_selected_test_o(run), .toggle_outputs_only_o(tog), .operation_select_o(ops),
    .pin_cell_chain_o(chn), .pin_cell_shift_o(shf));
  bsrs_tap_master m (.clk_i(clk_i), .tdo_i(tdo), .tck_o(tck), .tdi_o(tdi), .st_o(st));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task close_out;
    begin
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task ir(input [7:0] c);
    begin
      m.scan(1'b1, {10'h0, c}, 8, d);
      `CHK(d[7:0], 8'h81)
      `CHK(ins, c)
    end
  endtask
  ////////////////////////////////////////
  initial begin
    #400000;
    num_errors = num_errors + 1;
    close_out;
  end
  initial begin
    num_errors = 0;
    checked = 0;
    rst_i = 1'b1;
    alt = 1'b0;
    obs = 18'h2a5c3;
    altd = 18'h0f0f3;
    repeat (2) @(posedge clk_i);
    #1 rst_i = 1'b0;
    repeat (4) @(posedge clk_i);
    #1 `CHK(ins, `BSRS_IR_RESET)
    `CHK(ops, `BSRS_OPS_RESET)
    repeat (2) m.step(8'h01, 1'b0, q);
    $display("test reset done");
    // odd codes carry the top bit; last two are unlisted codes
    for (i = 0; i < 18; i = i + 1) begin
      v = (i < 16) ? {i[0], 3'h0, i[3:0]} : ((i == 16) ? 8'h10 : 8'hfe);
      ir(v);
    end
    $display("test decode done");
    ir(8'h02);
    m.scan(1'b0, 18'h1b0f5, 18, d);
    `CHK(d, obs)
    `CHK(chn, 18'h1b0f5)
    ir(8'h0e);
    m.scan(1'b0, 18'h1, 2, d);
    `CHK(d[1:0], `BSRS_OPS_RESET)
    `CHK(ops, 2'h1)
    ir(8'h89);
    `CHK(run, 1'b1)
    m.step(8'h00, 1'b0, q);
    `CHK(run, 1'b0)
    $display("test chain done");
    repeat (2) m.step(8'h80, 1'b0, q);
    `CHK(ins, `BSRS_IR_RESET)
    `CHK(ops, `BSRS_OPS_RESET)
    `CHK(chn, 18'h1b0f5)
    m.scan(1'b0, 18'h3, 2, d);
    `CHK(d[1:0], 2'h2)
    ir(8'h8c);
    `CHK(csrc, `BSRS_CAP_INVERT)
    m.scan(1'b0, 18'h0, 18, d);
    `CHK(d, ~18'h1b0f5)
    $display("test tap reset done");
    ir(8'h0d);
    alt = 1'b1;
    repeat (2) m.step(8'h01, 1'b0, q);
    alt = 1'b0;
    m.step(8'h01, 1'b0, q);
    `CHK(tog, 1'b1)
    `CHK(chn, altd)
    `CHK(shf, altd)
    ir(8'h0a);
    `CHK(csrc, `BSRS_CAP_HOLD)
    m.scan(1'b0, 18'h0, 18, d);
    `CHK(d, altd)
    $display("test run idle done");
    close_out;
  end
endmodule
